// ===== logic/codec_ctrl_pkg.sv
/*
 * Constants, field positions and reset values of the codec volume and filter
 * control register group.
 * Assumes a single 20 MHz system clock and an active-low power-down reset.
 */
package codec_ctrl_pkg;

    // Register addresses on the control port
    localparam logic [6:0] RECORD_TARGET_ADDR     = 7'h08;
    localparam logic [6:0] LEFT_INPUT_VOL_ADDR    = 7'h09;
    localparam logic [6:0] LEFT_OUTPUT_VOL_ADDR   = 7'h0a;
    localparam logic [6:0] LEVEL_MODE_THREE_ADDR  = 7'h0b;
    localparam logic [6:0] RIGHT_INPUT_VOL_ADDR   = 7'h0c;
    localparam logic [6:0] CURRENT_GAIN_ADDR      = 7'h0d;
    localparam logic [6:0] PLAYBACK_MODE_ADDR     = 7'h0e;
    localparam logic [6:0] INPUT_LINK_ADDR        = 7'h0f;
    localparam logic [6:0] RECORD_POWER_ADDR      = 7'h10;
    localparam logic [6:0] FILTER_SELECT_ADDR     = 7'h11;
    localparam logic [6:0] RIGHT_OUTPUT_VOL_ADDR  = 7'h25;

    // Reset values
    localparam logic [7:0] INPUT_VOL_RESET        = 8'he1;
    localparam logic [7:0] RECORD_TARGET_RESET    = 8'he1;
    localparam logic [7:0] OUTPUT_VOL_RESET       = 8'h91;
    localparam logic [5:0] PLAYBACK_TARGET_RESET  = 6'h28;
    localparam logic [1:0] DEEMPHASIS_RESET       = 2'h1;
    localparam logic [1:0] ATTENUATION_RESET      = 2'h0;
    localparam logic       OUTPUT_LINK_RESET      = 1'b1;
    localparam logic       INPUT_LINK_RESET       = 1'b1;
    localparam logic       WIND_FILTER_RESET      = 1'b1;

    // Field positions
    localparam int RECOVERY_STEP_BIT  = 7;
    localparam int LIMITER_LEVEL_BIT  = 6;
    localparam int READ_ENABLE_BIT    = 7;
    localparam int LOOPBACK_BIT       = 6;
    localparam int SOFT_MUTE_BIT      = 5;
    localparam int OUTPUT_LINK_BIT    = 4;
    localparam int INPUT_LINK_BIT     = 3;
    localparam int RIGHT_DIFF_BIT     = 4;
    localparam int LEFT_DIFF_BIT      = 3;
    localparam int RIGHT_SOURCE_BIT   = 2;
    localparam int LEFT_SOURCE_BIT    = 1;
    localparam int RIGHT_POWER_BIT    = 0;
    localparam int LOW_PASS_BIT       = 5;
    localparam int HIGH_PASS_BIT      = 4;
    localparam int GAIN_COMP_BIT      = 3;
    localparam int SEPARATION_BIT     = 2;
    localparam int WIND_FILTER_BIT    = 0;

    // Serial frame: R/W bit, 7 address bits, 8 data bits
    localparam int          FRAME_BITS   = 16;
    localparam logic [4:0]  FRAME_LAST   = 5'd15;
    localparam logic [4:0]  ADDR_LAST    = 5'd7;

    typedef enum logic [1:0] {
        PORT_IDLE  = 2'b00,
        PORT_ADDR  = 2'b01,
        PORT_WRITE = 2'b10,
        PORT_READ  = 2'b11
    } port_state_t;

endpackage : codec_ctrl_pkg

// ===== logic/codec_volume_filter_regs.sv
/*
 * Volume, level-control target, playback mode, input routing and filter
 * enable registers of the codec, written over the three-wire control port.
 * Assumes rst_b is the power-down pin and all pins are synchronous to ref_clk.
 */
module codec_volume_filter_regs
    import codec_ctrl_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       csn_b,
    input  wire logic       cclk,
    input  wire logic       cdti,
    output logic            cdto,
    output logic            cdto_oe,
    input  wire logic [7:0] level_gain_in,
    output logic [7:0]      left_input_level,
    output logic [7:0]      right_input_level,
    output logic [7:0]      left_output_level,
    output logic [7:0]      right_output_level,
    output logic [7:0]      record_recovery_target,
    output logic [5:0]      playback_recovery_target,
    output logic            limiter_level_high_bit,
    output logic            recovery_step_high_bit,
    output logic [1:0]      deemphasis_select,
    output logic [1:0]      output_attenuation_step,
    output logic            soft_mute_request,
    output logic            dac_from_serial_out,
    output logic            right_record_power,
    output logic            left_source_select,
    output logic            right_source_select,
    output logic            left_differential_select,
    output logic            right_differential_select,
    output logic            adc_wind_filter_enable,
    output logic            separation_filter_enable,
    output logic            gain_comp_filter_enable,
    output logic            high_pass_enable,
    output logic            low_pass_enable,
    output logic [1:0]      filter_block_gain
);

    typedef struct packed {
        logic [7:0] left_input_volume;
        logic [7:0] right_input_volume;
        logic [7:0] left_output_volume;
        logic [7:0] right_output_volume;
        logic [7:0] record_target;
        logic [7:0] level_mode_three;
        logic [7:0] playback_mode;
        logic       input_link;
        logic [4:0] record_power;
        logic [7:0] filter_select;
        logic [7:0] in_left;
        logic [7:0] in_right;
        logic [7:0] out_left;
        logic [7:0] out_right;
        logic [7:0] read_word;
        logic       dout;
        logic       dout_en;
    } regs_t;

    regs_t cur;
    regs_t next_cur;

    logic       wr_strobe;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic [6:0] rd_addr;
    logic [7:0] held_gain;
    logic       port_dout;
    logic       port_dout_en;

    // Read mux; reserved bits are zero
    function automatic logic [7:0] read_mux(input regs_t r, input logic [6:0] a,
                                            input logic [7:0] gain);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            RECORD_TARGET_ADDR:    v = r.record_target;
            LEFT_INPUT_VOL_ADDR:   v = r.left_input_volume;
            LEFT_OUTPUT_VOL_ADDR:  v = r.left_output_volume;
            LEVEL_MODE_THREE_ADDR: v = r.level_mode_three;
            RIGHT_INPUT_VOL_ADDR:  v = r.right_input_volume;
            CURRENT_GAIN_ADDR:     v = gain;
            PLAYBACK_MODE_ADDR:    v = r.playback_mode;
            INPUT_LINK_ADDR:       v = {4'h0, r.input_link, 3'h0};
            RECORD_POWER_ADDR:     v = {3'h0, r.record_power};
            FILTER_SELECT_ADDR:    v = {r.filter_select[7:2], 1'b0,
                                        r.filter_select[0]};
            RIGHT_OUTPUT_VOL_ADDR: v = r.right_output_volume;
            default:               v = 8'h00;
        endcase
        return v;
    endfunction : read_mux

    serial_ctrl_port u_port (
        .ref_clk      (ref_clk),
        .rst_b        (rst_b),
        .csn_b        (csn_b),
        .cclk         (cclk),
        .cdti         (cdti),
        .read_data    (cur.read_word),
        .read_allowed (cur.playback_mode[READ_ENABLE_BIT]),
        .wr_strobe    (wr_strobe),
        .wr_addr      (wr_addr),
        .wr_data      (wr_data),
        .rd_addr      (rd_addr),
        .cdto         (port_dout),
        .cdto_oe      (port_dout_en)
    );

    level_gain_hold u_gain (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .gain_in  (level_gain_in),
        .gain_out (held_gain)
    );

    // Register writes and effective level computation
    always_comb begin
        next_cur = cur;
        next_cur.read_word = read_mux(cur, rd_addr, held_gain);
        if (wr_strobe) begin
            unique case (wr_addr)
                RECORD_TARGET_ADDR:    next_cur.record_target = wr_data;
                // Linked mode feeds left into the right level, not into the right register
                LEFT_INPUT_VOL_ADDR:   next_cur.left_input_volume = wr_data;
                LEFT_OUTPUT_VOL_ADDR:  next_cur.left_output_volume = wr_data;
                LEVEL_MODE_THREE_ADDR: next_cur.level_mode_three = wr_data;
                RIGHT_INPUT_VOL_ADDR:  next_cur.right_input_volume = wr_data;
                PLAYBACK_MODE_ADDR:    next_cur.playback_mode = wr_data;
                INPUT_LINK_ADDR:       next_cur.input_link = wr_data[INPUT_LINK_BIT];
                RECORD_POWER_ADDR:     next_cur.record_power = wr_data[4:0];
                FILTER_SELECT_ADDR:    next_cur.filter_select = {wr_data[7:2], 1'b0,
                                                                 wr_data[0]};
                RIGHT_OUTPUT_VOL_ADDR: next_cur.right_output_volume = wr_data;
                default: ; // gain register and unmapped addresses
            endcase
        end
        next_cur.in_left  = cur.left_input_volume;
        next_cur.in_right = cur.input_link ? cur.left_input_volume
                                           : cur.right_input_volume;
        next_cur.out_left  = cur.left_output_volume;
        next_cur.out_right = cur.playback_mode[OUTPUT_LINK_BIT]
                           ? cur.left_output_volume
                           : cur.right_output_volume;
        // Pin flops here so the pad never sees port logic
        next_cur.dout    = port_dout;
        next_cur.dout_en = port_dout_en;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur.left_input_volume   <= INPUT_VOL_RESET;
            cur.right_input_volume  <= INPUT_VOL_RESET;
            cur.left_output_volume  <= OUTPUT_VOL_RESET;
            cur.right_output_volume <= OUTPUT_VOL_RESET;
            cur.record_target       <= RECORD_TARGET_RESET;
            cur.level_mode_three    <= {2'h0, PLAYBACK_TARGET_RESET};
            cur.playback_mode       <= {3'h0, OUTPUT_LINK_RESET, ATTENUATION_RESET,
                                        DEEMPHASIS_RESET};
            cur.input_link          <= INPUT_LINK_RESET;
            cur.record_power        <= 5'h00;
            cur.filter_select       <= {7'h00, WIND_FILTER_RESET};
            cur.in_left             <= INPUT_VOL_RESET;
            cur.in_right            <= INPUT_VOL_RESET;
            cur.out_left            <= OUTPUT_VOL_RESET;
            cur.out_right           <= OUTPUT_VOL_RESET;
            cur.read_word           <= 8'h00;
            cur.dout                <= 1'b0;
            cur.dout_en             <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    // Field fan-out, all straight from registers
    assign cdto                      = cur.dout;
    assign cdto_oe                   = cur.dout_en;
    assign left_input_level          = cur.in_left;
    assign right_input_level         = cur.in_right;
    assign left_output_level         = cur.out_left;
    assign right_output_level        = cur.out_right;
    assign record_recovery_target    = cur.record_target;
    assign playback_recovery_target  = cur.level_mode_three[5:0];
    assign limiter_level_high_bit    = cur.level_mode_three[LIMITER_LEVEL_BIT];
    assign recovery_step_high_bit    = cur.level_mode_three[RECOVERY_STEP_BIT];
    assign deemphasis_select         = cur.playback_mode[1:0];
    assign output_attenuation_step   = cur.playback_mode[3:2];
    assign soft_mute_request         = cur.playback_mode[SOFT_MUTE_BIT];
    assign dac_from_serial_out       = cur.playback_mode[LOOPBACK_BIT];
    assign right_record_power        = cur.record_power[RIGHT_POWER_BIT];
    assign left_source_select        = cur.record_power[LEFT_SOURCE_BIT];
    assign right_source_select       = cur.record_power[RIGHT_SOURCE_BIT];
    assign left_differential_select  = cur.record_power[LEFT_DIFF_BIT];
    assign right_differential_select = cur.record_power[RIGHT_DIFF_BIT];
    assign adc_wind_filter_enable    = cur.filter_select[WIND_FILTER_BIT];
    assign separation_filter_enable  = cur.filter_select[SEPARATION_BIT];
    assign gain_comp_filter_enable   = cur.filter_select[GAIN_COMP_BIT];
    assign high_pass_enable          = cur.filter_select[HIGH_PASS_BIT];
    assign low_pass_enable           = cur.filter_select[LOW_PASS_BIT];
    assign filter_block_gain         = cur.filter_select[7:6];

endmodule : codec_volume_filter_regs

// ===== logic/level_gain_hold.sv
/*
 * Holds the live level-control gain reported by the gain engine so that a
 * read over the control port sees a stable registered value.
 * Assumes the engine drives its gain synchronous to ref_clk.
 */
module level_gain_hold
    import codec_ctrl_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic [7:0] gain_in,
    output logic [7:0]      gain_out
);

    typedef struct packed {
        logic [7:0] gain;
    } hold_reg_t;

    hold_reg_t cur;
    hold_reg_t next_cur;

    // No defined reset meaning; zero only keeps simulation clean
    always_comb begin
        next_cur      = cur;
        next_cur.gain = gain_in;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign gain_out = cur.gain;

endmodule : level_gain_hold

// ===== logic/serial_ctrl_port.sv
/*
 * Three-wire serial control port: chip select, bit clock (sampled) and data.
 * Frame: R/W bit, 7 address bits, 8 data bits, MSB first, rising bit clock.
 * Assumes pins synchronous to ref_clk and the bit clock far slower than it.
 */
module serial_ctrl_port
    import codec_ctrl_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       csn_b,
    input  wire logic       cclk,
    input  wire logic       cdti,
    input  wire logic [7:0] read_data,
    input  wire logic       read_allowed,
    output logic            wr_strobe,
    output logic [6:0]      wr_addr,
    output logic [7:0]      wr_data,
    output logic [6:0]      rd_addr,
    output logic            cdto,
    output logic            cdto_oe
);

    typedef struct packed {
        port_state_t state;
        logic        cclk_d;
        logic [4:0]  count;
        logic [7:0]  shift_in;
        logic [7:0]  shift_out;
        logic        is_read;
        logic [6:0]  addr;
        logic        strobe;
        logic [7:0]  data;
        logic        dout;
        logic        dout_en;
    } port_reg_t;

    port_reg_t cur;
    port_reg_t next_cur;

    // Frame sequencing on bit-clock edges
    always_comb begin
        next_cur = cur;
        next_cur.cclk_d = cclk;
        next_cur.strobe = 1'b0;
        if (csn_b) begin
            next_cur.state   = PORT_IDLE;
            next_cur.count   = 5'd0;
            next_cur.dout_en = 1'b0;
        end else begin
            if (cur.state == PORT_IDLE) begin
                next_cur.state = PORT_ADDR;
            end
            if (cclk && !cur.cclk_d) begin
                next_cur.shift_in = {cur.shift_in[6:0], cdti};
                next_cur.count = cur.count + 5'd1;
                unique case (cur.state)
                    PORT_IDLE, PORT_ADDR: begin
                        if (cur.count == ADDR_LAST) begin
                            next_cur.is_read = cur.shift_in[6];
                            next_cur.addr    = {cur.shift_in[5:0], cdti};
                            // Denied reads just leave the output pin undriven
                            if (cur.shift_in[6] && read_allowed) begin
                                next_cur.state     = PORT_READ;
                                next_cur.shift_out = read_data;
                            end else begin
                                next_cur.state = PORT_WRITE;
                            end
                        end
                    end
                    PORT_WRITE: begin
                        if (cur.count == FRAME_LAST && !cur.is_read) begin
                            next_cur.strobe = 1'b1;
                            next_cur.data   = {cur.shift_in[6:0], cdti};
                        end
                    end
                    PORT_READ: begin
                        next_cur.shift_out = {cur.shift_out[6:0], 1'b0};
                    end
                endcase
            end
            // Pin shows the shifter MSB in the read phase
            if (cur.state == PORT_READ) begin
                next_cur.dout_en = 1'b1;
                next_cur.dout    = cur.shift_out[7];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign wr_strobe = cur.strobe;
    assign wr_addr   = cur.addr;
    assign wr_data   = cur.data;
    assign rd_addr   = {cur.shift_in[5:0], cdti};
    assign cdto      = cur.dout;
    assign cdto_oe   = cur.dout_en;

endmodule : serial_ctrl_port

// ===== tb/codec_regs_monitor.sv
/*
 * Checker: reset values, quiet port idle, timing of the read drive.
 * Assumes it is bound to the top module and sees its ports only.
 */
module codec_regs_monitor
    import codec_ctrl_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       rst_b,
    input wire logic       csn_b,
    input wire logic       cdto_oe,
    input wire logic [7:0] left_input_level,
    input wire logic [7:0] right_input_level,
    input wire logic [7:0] left_output_level,
    input wire logic [7:0] right_output_level,
    input wire logic [7:0] record_recovery_target,
    input wire logic [5:0] playback_recovery_target,
    input wire logic [1:0] deemphasis_select,
    input wire logic [1:0] output_attenuation_step,
    input wire logic       soft_mute_request,
    input wire logic       adc_wind_filter_enable,
    input wire logic       separation_filter_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    // Cycles since chip select went high; saturates so it never wraps
    logic [3:0] idle_count;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            idle_count <= 4'h0;
        end else if (!csn_b) begin
            idle_count <= 4'h0;
        end else if (idle_count != 4'hf) begin
            idle_count <= idle_count + 4'h1;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // First edge after power-down ends
    a_reset_in_volume: assert property (
        $rose(rst_b) |-> left_input_level == INPUT_VOL_RESET
                         && right_input_level == INPUT_VOL_RESET)
        else $error("input volume not at reset value");
    a_reset_out_volume: assert property (
        $rose(rst_b) |-> left_output_level == OUTPUT_VOL_RESET
                         && right_output_level == OUTPUT_VOL_RESET)
        else $error("output volume not at reset value");
    a_reset_targets: assert property (
        $rose(rst_b) |-> record_recovery_target == RECORD_TARGET_RESET
                         && playback_recovery_target == PLAYBACK_TARGET_RESET)
        else $error("recovery targets not at reset value");
    a_reset_play_mode: assert property (
        $rose(rst_b) |-> deemphasis_select == DEEMPHASIS_RESET
                         && output_attenuation_step == ATTENUATION_RESET && !soft_mute_request)
        else $error("playback mode not at reset value");
    a_reset_filters: assert property (
        $rose(rst_b) |-> adc_wind_filter_enable == WIND_FILTER_RESET
                         && !separation_filter_enable)
        else $error("filter enables not at reset value");
    // Levels, recovery targets, de-emphasis and soft mute never move after four idle cycles
    a_idle_hold: assert property (
        idle_count >= 4'h4 |-> $stable({left_input_level, right_input_level,
            left_output_level, right_output_level, record_recovery_target,
            playback_recovery_target, deemphasis_select, soft_mute_request}))
        else $error("setting changed while port idle");
    a_idle_no_drive: assert property (
        idle_count >= 4'h2 |-> !cdto_oe)
        else $error("read data driven outside a frame");
    a_drive_not_early: assert property (
        $fell(csn_b) |-> !cdto_oe [*8])
        else $error("read data driven before address phase ends");
endmodule : codec_regs_monitor

bind codec_volume_filter_regs codec_regs_monitor u_monitor (.*);

// ===== tb/ctrl_host_model.sv
/*
 * Host side of the three-wire control port: sends one frame per call.
 * Assumes ref_clk runs free; bit clock phases are whole ref_clk cycles.
 */
module ctrl_host_model (
    input  wire logic ref_clk,
    output logic      csn_b,
    output logic      cclk,
    output logic      cdti,
    input  wire logic cdto,
    input  wire logic cdto_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle port: deselected, bit clock parked low
    initial begin
        csn_b = 1'b1;
        cclk  = 1'b0;
        cdti  = 1'b0;
    end

    // Fewer than 16 bits cuts the frame short
    task automatic frame(input logic rd, input logic [6:0] addr, input logic [7:0] wdata,
                         input int bits, output logic [7:0] rdata, output logic driven);
        logic [15:0] word;
        word = {rd, addr, wdata};
        rdata = 8'h00;
        driven = 1'b0;
        @(posedge ref_clk);
        csn_b <= 1'b0;
        for (int i = 15; i >= 16 - bits; i--) begin
            cclk <= 1'b0;
            cdti <= word[i];
            repeat (3) @(posedge ref_clk);
            cclk <= 1'b1;
            // Four cycles high so the registered read bit has landed
            repeat (4) @(posedge ref_clk);
            if (i >= 1 && i <= 8) begin
                rdata[i - 1] = cdto;
                driven = driven | cdto_oe;
            end
        end
        cclk <= 1'b0;
        repeat (3) @(posedge ref_clk);
        csn_b <= 1'b1;
        cdti <= ~cdti;
        repeat (3) @(posedge ref_clk);
    endtask : frame
endmodule : ctrl_host_model

// ===== tb/tb_top.sv
/*
 * Codec register group bench: clock, reset, host model, scenarios.
 * Assumes the checker binds itself from its own file.
 */
module tb_top
    import codec_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       ref_clk, rst_b, csn_b, cclk, cdti, cdto, cdto_oe;
    logic [7:0] level_gain_in, left_input_level, right_input_level;
    logic [7:0] left_output_level, right_output_level, record_recovery_target;
    logic [5:0] playback_recovery_target;
    logic [1:0] deemphasis_select, output_attenuation_step, filter_block_gain;
    logic       limiter_level_high_bit, recovery_step_high_bit, soft_mute_request;
    logic       dac_from_serial_out, right_record_power, left_source_select;
    logic       right_source_select, left_differential_select, right_differential_select;
    logic       adc_wind_filter_enable, separation_filter_enable, gain_comp_filter_enable;
    logic       high_pass_enable, low_pass_enable;
    int         num_errors, samples_checked;

    codec_volume_filter_regs dut (
        .ref_clk, .rst_b, .csn_b, .cclk, .cdti, .cdto, .cdto_oe, .level_gain_in,
        .left_input_level, .right_input_level, .left_output_level, .right_output_level,
        .record_recovery_target, .playback_recovery_target, .limiter_level_high_bit,
        .recovery_step_high_bit, .deemphasis_select, .output_attenuation_step,
        .soft_mute_request, .dac_from_serial_out, .right_record_power, .left_source_select,
        .right_source_select, .left_differential_select, .right_differential_select,
        .adc_wind_filter_enable, .separation_filter_enable, .gain_comp_filter_enable,
        .high_pass_enable, .low_pass_enable, .filter_block_gain
    );
    ctrl_host_model host (.ref_clk, .csn_b, .cclk, .cdti, .cdto, .cdto_oe);

    // 50 ns system clock
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic       oe;
        host.frame(1'b0, a, d, 16, r, oe);
    endtask : wr
    // Data judged only when a drive is expected
    task automatic rd(input logic [6:0] a, input logic [7:0] exp, input logic en);
        logic [7:0] r;
        logic       oe;
        host.frame(1'b1, a, 8'h00, 16, r, oe);
        chk({7'h0, oe, en ? r : 8'h00}, {7'h0, en, en ? exp : 8'h00});
    endtask : rd
    // Output groups packed in their register bit order
    function automatic logic [7:0] mode_now();
        return {1'b0, dac_from_serial_out, soft_mute_request, 1'b0,
                output_attenuation_step, deemphasis_select};
    endfunction : mode_now
    function automatic logic [7:0] route_now();
        return {3'h0, right_differential_select, left_differential_select,
                right_source_select, left_source_select, right_record_power};
    endfunction : route_now
    function automatic logic [7:0] filt_now();
        return {filter_block_gain, low_pass_enable, high_pass_enable,
                gain_comp_filter_enable, separation_filter_enable, 1'b0, adc_wind_filter_enable};
    endfunction : filt_now

    task automatic do_reset();
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask : do_reset
    task automatic test_reset();
        chk({left_input_level, right_input_level}, 16'he1e1);
        chk({left_output_level, right_output_level}, 16'h9191);
        chk({record_recovery_target, 8'h00}, 16'he100);
        chk(16'({recovery_step_high_bit, limiter_level_high_bit,
                 playback_recovery_target}), 16'h0028);
        chk({mode_now(), filt_now()}, 16'h0101);
        chk({route_now(), 8'h00}, 16'h0000);
        rd(7'h0e, 8'h00, 1'b0);
    endtask : test_reset
    task automatic test_readback();
        wr(7'h0e, 8'h91);
        rd(7'h0e, 8'h91, 1'b1);
        level_gain_in <= 8'h5a;
        rd(7'h0d, 8'h5a, 1'b1);
        wr(7'h0d, 8'h33);
        level_gain_in <= 8'ha5;
        rd(7'h0d, 8'ha5, 1'b1);
    endtask : test_readback
    task automatic test_links();
        wr(7'h0a, 8'h40);
        wr(7'h25, 8'h70);
        chk({left_output_level, right_output_level}, 16'h4040);
        rd(7'h25, 8'h70, 1'b1);
        wr(7'h0e, 8'h81);
        chk({left_output_level, right_output_level}, 16'h4070);
        wr(7'h09, 8'h10);
        wr(7'h0c, 8'h20);
        wr(7'h0f, 8'hff);
        chk({left_input_level, right_input_level}, 16'h1010);
        rd(7'h0f, 8'h08, 1'b1);
        wr(7'h0f, 8'h00);
        chk({left_input_level, right_input_level}, 16'h1020);
    endtask : test_links
    task automatic test_mode();
        logic [7:0] v [6] = '{8'h20, 8'h40, 8'h0c, 8'h08, 8'h02, 8'h03};
        foreach (v[i]) begin
            wr(7'h0e, 8'h80 | v[i]);
            chk({8'h00, mode_now()}, {8'h00, v[i] & 8'h6f});
        end
    endtask : test_mode
    task automatic test_routing();
        logic [7:0] v [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'hff};
        foreach (v[i]) begin
            wr(7'h10, v[i]);
            chk({8'h00, route_now()}, {8'h00, v[i] & 8'h1f});
        end
        rd(7'h10, 8'h1f, 1'b1);
    endtask : test_routing
    task automatic test_filters();
        logic [7:0] v [9] = '{8'h00, 8'h01, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'hff};
        foreach (v[i]) begin
            wr(7'h11, v[i]);
            chk({8'h00, filt_now()}, {8'h00, v[i] & 8'hfd});
        end
        rd(7'h11, 8'hfd, 1'b1);
    endtask : test_filters
    task automatic test_targets();
        logic [7:0] r;
        logic       oe;
        wr(7'h08, 8'h3c);
        chk({8'h00, record_recovery_target}, 16'h003c);
        wr(7'h0b, 8'hc5);
        chk(16'({recovery_step_high_bit, limiter_level_high_bit,
                 playback_recovery_target}), 16'h00c5);
        wr(7'h0b, 8'h40);
        rd(7'h0b, 8'h40, 1'b1);
        // A 12-bit cut frame must not write
        host.frame(1'b0, 7'h0a, 8'h22, 12, r, oe);
        chk({8'h00, left_output_level}, 16'h0040);
    endtask : test_targets

    task automatic tally_and_finish();
        $display("Checks %0d, errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    // Hang guard, far above the frame traffic
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        tally_and_finish();
    end

    // Second power-down must restore every setting
    initial begin
        rst_b = 1'b0;
        level_gain_in = 8'h00;
        do_reset();
        test_reset();
        test_readback();
        test_links();
        test_mode();
        test_routing();
        test_filters();
        test_targets();
        do_reset();
        test_reset();
        tally_and_finish();
    end
endmodule : tb_top
